/* File: rtl/fnv_pkg.sv */
// Constants and types shared by the flash non-volatile bit and boot map logic.
// Assumes one 25 MHz clock domain; addresses are 32-bit byte addresses.
package fnv_pkg;
  // Fixed memory bases, compared on the 1 Mbyte region field
  localparam logic [31:0] ZERO_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_BASE = 32'h0010_0000;
  localparam logic [31:0] SRAM_BASE = 32'h0020_0000;
  localparam logic [31:0] ROM_BASE = 32'h0030_0000;
  localparam int REGION_MSB = 31;
  localparam int REGION_LSB = 20;
  localparam int OFFSET_W = 20;
  // General-purpose non-volatile bit positions
  localparam int GP_BROWNOUT_EN = 0;
  localparam int GP_BROWNOUT_RST = 1;
  localparam int GP_BOOT_FLASH = 2;
  localparam int GP_COUNT = 3;
  localparam logic [GP_COUNT-1:0] GP_RESET = 3'h0;
  // Page, write buffer and lock geometry
  localparam int PAGE_BYTES = 256;
  localparam int WORD_BYTES = 4;
  localparam int WBUF_WORDS = PAGE_BYTES / WORD_BYTES;
  localparam int WBUF_IDX_W = 6;
  localparam int PAGE_W = 10;
  localparam int PAGES_PER_LOCK = 64;
  localparam int LOCK_SHIFT = 6;
  localparam int LOCKS_LARGE = 16;
  localparam int LOCKS_SMALL = 8;
  // Prefetch buffer and flash word address
  localparam int PF_ENTRIES = 2;
  localparam int FLASH_WORD_W = 16;
  // Factory calibration bits
  localparam int CALIB_W = 8;
  localparam logic [CALIB_W-1:0] CALIB_RESET = 8'h00;
  // Erase pin debounce
  localparam int ERASE_MIN_MS = 200;
  localparam int CLK_HZ = 25_000_000;
  localparam int ERASE_CYCLES = ERASE_MIN_MS * (CLK_HZ / 1000);
  // Commands taken on the command port
  typedef enum logic [3:0] {
    CMD_PROG_PAGE, CMD_ERASE_PAGE, CMD_ERASE_ALL, CMD_SET_LOCK, CMD_CLR_LOCK,
    CMD_SET_GP, CMD_CLR_GP, CMD_SET_SEC, CMD_REMAP
  } fnv_cmd_e;
  // Who issues a command or access
  typedef enum logic [1:0] {SRC_CPU, SRC_DEBUG, SRC_FASTPROG} fnv_src_e;
  // Decoded target memory
  typedef enum logic [1:0] {RG_NONE, RG_FLASH, RG_SRAM, RG_ROM} fnv_region_e;
endpackage : fnv_pkg

/* File: rtl/fnv_addr_decode.sv */
// Combinational address decoder for the internal memory map.
// Assumes remap and boot select come from flops in the caller.
module fnv_addr_decode
  import fnv_pkg::*;
(
  // Request
  input wire logic [31:0] addr,
  // Map state
  input wire logic remap,
  input wire logic boot_flash,
  // Result
  output fnv_region_e region,
  output logic [OFFSET_W-1:0] offset
);
  logic [11:0] field; // 1 Mbyte region number

  assign field = addr[REGION_MSB:REGION_LSB];
  assign offset = addr[OFFSET_W-1:0];

  // Fixed bases always decode; the zero window follows remap then boot select
  always_comb begin
    if (field == FLASH_BASE[REGION_MSB:REGION_LSB]) begin
      region = RG_FLASH;
    end else if (field == SRAM_BASE[REGION_MSB:REGION_LSB]) begin
      region = RG_SRAM;
    end else if (field == ROM_BASE[REGION_MSB:REGION_LSB]) begin
      region = RG_ROM;
    end else if (field == ZERO_BASE[REGION_MSB:REGION_LSB]) begin
      // Remap overrides boot selection
      if (remap) begin
        region = RG_SRAM;
      end else if (boot_flash) begin
        region = RG_FLASH;
      end else begin
        region = RG_ROM;
      end
    end else begin
      region = RG_NONE;
    end
  end
endmodule : fnv_addr_decode

/* File: rtl/fnv_erase_debounce.sv */
// Erase pin synchroniser and long debounce filter.
// Assumes the pin is asynchronous; emits one pulse per accepted assertion.
module fnv_erase_debounce #(
  parameter int CYCLES = 5_000_000
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Pin and result
  input wire logic erase_pin,
  output logic erase_pulse
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CYCLES);
  logic sync_a; // First stage, read only by sync_b
  logic sync_b; // Safe level
  logic [CNT_W-1:0] held; // Cycles the pin stayed high
  logic fired; // Pulse already given for this assertion

  // Two-stage synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else if (clk_en) begin
      sync_a <= erase_pin;
      sync_b <= sync_a;
    end
  end

  // Count a continuous high level; any low restarts, so glitches never erase
  always_ff @(posedge clk) begin
    if (reset) begin
      held <= '0;
      fired <= 1'b0;
      erase_pulse <= 1'b0;
    end else if (clk_en) begin
      erase_pulse <= 1'b0;
      if (!sync_b) begin
        held <= '0;
        fired <= 1'b0;
      end else if (held != CNT_MAX) begin
        held <= held + 1'b1;
      end else if (!fired) begin
        erase_pulse <= 1'b1;
        fired <= 1'b1;
      end
    end
  end

  a_erase_held: assert property (
    @(posedge clk) disable iff (reset)
    $rose(erase_pulse) |-> $past(held) == CNT_MAX && $past(sync_b))
    else $error("erase accepted before debounce time");
endmodule : fnv_erase_debounce

/* File: rtl/fnv_nvm_ctrl.sv */
// Flash non-volatile bits, lock regions, security, boot map, write and prefetch buffers.
// Assumes external SRAM/ROM serve data for their regions and the flash array
// raises op_done after a program or erase; all pins are asynchronous.
module fnv_nvm_ctrl
  import fnv_pkg::*;
#(
  parameter int NUM_LOCKS = LOCKS_LARGE,
  parameter int ERASE_DEBOUNCE = ERASE_CYCLES,
  parameter logic [CALIB_W-1:0] CALIB_VALUE = CALIB_RESET
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Pins
  input wire logic erase_pin,
  input wire logic test_mode_pin,
  input wire logic port_a_line_zero,
  input wire logic port_a_line_one,
  // Command port
  input wire logic cmd_valid,
  input wire fnv_cmd_e cmd_code,
  input wire fnv_src_e cmd_src,
  input wire logic [PAGE_W-1:0] cmd_arg,
  output logic cmd_busy,
  output logic cmd_done,
  output logic cmd_refused,
  output logic lock_abort,
  // Memory access port
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire fnv_src_e acc_src,
  input wire logic [31:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  output logic acc_ack,
  output logic acc_refused,
  output fnv_region_e acc_region,
  output logic [OFFSET_W-1:0] acc_offset,
  output logic [31:0] acc_rdata,
  // Flash array side
  output logic flash_rd_req,
  output logic [FLASH_WORD_W-1:0] flash_rd_addr,
  input wire logic flash_rd_valid,
  input wire logic [31:0] flash_rd_data,
  output logic flash_op_start,
  output fnv_cmd_e flash_op_code,
  output logic [PAGE_W-1:0] flash_op_page,
  input wire logic flash_op_done,
  input wire logic [WBUF_IDX_W-1:0] flash_wbuf_idx,
  output logic [31:0] flash_wbuf_data,
  output logic flash_standby,
  // Status and system controls
  output logic remap,
  output logic [GP_COUNT-1:0] general_purpose_nv_bit,
  output logic [NUM_LOCKS-1:0] lock_bits,
  output logic security_on,
  output logic fast_prog_mode,
  output logic [CALIB_W-1:0] calib_bits
);
  localparam int LIDX_W = $clog2(NUM_LOCKS);

  typedef enum logic [1:0] {C_IDLE, C_BUSY} fnv_cstate_e;
  typedef enum logic [1:0] {A_IDLE, A_FILL, A_PREF} fnv_astate_e;

  fnv_cstate_e cst; // Command sequencer state
  fnv_astate_e ast; // Access sequencer state
  logic [2:0] pin_ff1; // First sync stage, read only by pin_ff2
  logic [2:0] pin_ff2; // Synchronised test and port lines
  logic erase_pulse; // Debounced erase assertion
  logic erase_armed; // Erase pin seen; next full erase may drop security
  fnv_cmd_e busy_code; // Command the array is running
  logic [31:0] wbuf [WBUF_WORDS]; // Page write buffer
  logic [31:0] pf_data [PF_ENTRIES]; // Prefetch words
  logic [FLASH_WORD_W-1:0] pf_tag [PF_ENTRIES]; // Prefetch word addresses
  logic [PF_ENTRIES-1:0] pf_vld; // Prefetch entry valid
  logic [PF_ENTRIES-1:0] pf_hit; // Per-entry hit
  logic pf_victim; // Entry filled next
  fnv_region_e dec_region; // Decoded region of acc_addr
  logic [OFFSET_W-1:0] dec_offset; // Offset within region
  logic [FLASH_WORD_W-1:0] acc_word; // Flash word address of access
  logic acc_take; // Access accepted this cycle
  logic acc_deny; // Access must be refused
  logic cmd_take; // Command accepted this cycle
  logic cmd_page_locked; // Target page falls in a locked region
  logic cmd_deny; // Command must be refused
  logic any_lock; // Some region locked

  // Address map decode
  fnv_addr_decode u_decode (
    .addr(acc_addr),
    .remap(remap),
    .boot_flash(general_purpose_nv_bit[GP_BOOT_FLASH]),
    .region(dec_region),
    .offset(dec_offset)
  );

  // Erase pin filter, long count shortened in simulation by parameter
  fnv_erase_debounce #(.CYCLES(ERASE_DEBOUNCE)) u_erase (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .erase_pin(erase_pin),
    .erase_pulse(erase_pulse)
  );

  // Synchronise mode pins before any decision reads them
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_ff1 <= 3'h0;
      pin_ff2 <= 3'h0;
      fast_prog_mode <= 1'b0;
    end else if (clk_en) begin
      pin_ff1 <= {test_mode_pin, port_a_line_one, port_a_line_zero};
      pin_ff2 <= pin_ff1;
      fast_prog_mode <= &pin_ff2;
    end
  end

  // Calibration bits are loaded once and no path ever writes them
  always_ff @(posedge clk) begin
    if (reset) begin
      calib_bits <= CALIB_VALUE;
    end
  end

  assign acc_word = dec_offset[FLASH_WORD_W+1:2];
  assign acc_take = clk_en && acc_valid && (ast == A_IDLE);
  // Refuse unmapped, ROM writes, fast port outside its mode, secured flash except from the CPU
  assign acc_deny = (dec_region == RG_NONE)
    || (dec_region == RG_ROM && acc_write)
    || (acc_src == SRC_FASTPROG && !fast_prog_mode)
    || (security_on && acc_src != SRC_CPU && dec_region == RG_FLASH);

  // Prefetch hit per entry
  genvar gi;
  generate
    for (gi = 0; gi < PF_ENTRIES; gi++) begin : g_pf
      assign pf_hit[gi] = pf_vld[gi] && (pf_tag[gi] == acc_word);
    end
  endgenerate

  assign cmd_take = clk_en && cmd_valid && (cst == C_IDLE);
  assign any_lock = |lock_bits;
  assign cmd_page_locked = lock_bits[cmd_arg[LOCK_SHIFT +: LIDX_W]];
  // Fast port takes only its six kinds; security shuts debug and fast port
  always_comb begin
    cmd_deny = 1'b0;
    if (cmd_src == SRC_FASTPROG) begin
      cmd_deny = !fast_prog_mode || security_on
        || cmd_code == CMD_SET_GP || cmd_code == CMD_CLR_GP
        || cmd_code == CMD_REMAP;
    end else if (cmd_src == SRC_DEBUG) begin
      cmd_deny = security_on;
    end
    if ((cmd_code == CMD_SET_GP || cmd_code == CMD_CLR_GP)
        && cmd_arg >= PAGE_W'(GP_COUNT)) begin
      cmd_deny = 1'b1;
    end
  end

  // Command sequencer: checks, bit updates, array hand-off
  always_ff @(posedge clk) begin
    if (reset) begin
      cst <= C_IDLE;
      busy_code <= CMD_PROG_PAGE;
      cmd_done <= 1'b0;
      cmd_refused <= 1'b0;
      lock_abort <= 1'b0;
      cmd_busy <= 1'b0;
      flash_op_start <= 1'b0;
      flash_op_code <= CMD_PROG_PAGE;
      flash_op_page <= '0;
    end else if (clk_en) begin
      cmd_done <= 1'b0;
      cmd_refused <= 1'b0;
      lock_abort <= 1'b0;
      flash_op_start <= 1'b0;
      case (cst)
        C_IDLE: begin
          if (cmd_valid) begin
            if (cmd_deny) begin
              cmd_refused <= 1'b1;
            end else if (((cmd_code == CMD_PROG_PAGE || cmd_code == CMD_ERASE_PAGE)
                && cmd_page_locked) || (cmd_code == CMD_ERASE_ALL && any_lock)) begin
              lock_abort <= 1'b1;
            end else if (cmd_code == CMD_PROG_PAGE || cmd_code == CMD_ERASE_PAGE
                || cmd_code == CMD_ERASE_ALL) begin
              // Array work: wait for its completion
              flash_op_start <= 1'b1;
              flash_op_code <= cmd_code;
              flash_op_page <= cmd_arg;
              busy_code <= cmd_code;
              cmd_busy <= 1'b1;
              cst <= C_BUSY;
            end else begin
              cmd_done <= 1'b1;
            end
          end
        end
        C_BUSY: begin
          if (flash_op_done) begin
            cmd_done <= 1'b1;
            cmd_busy <= 1'b0;
            cst <= C_IDLE;
          end
        end
        default: begin
          cst <= C_IDLE;
          cmd_busy <= 1'b0;
        end
      endcase
    end
  end

  // General-purpose bits; the erase pin wins over a same-cycle set
  always_ff @(posedge clk) begin
    if (reset) begin
      general_purpose_nv_bit <= GP_RESET;
    end else if (clk_en) begin
      if (erase_pulse) begin
        general_purpose_nv_bit <= GP_RESET;
      end else if (cmd_take && !cmd_deny && cmd_code == CMD_SET_GP) begin
        general_purpose_nv_bit[cmd_arg[1:0]] <= 1'b1;
      end else if (cmd_take && !cmd_deny && cmd_code == CMD_CLR_GP) begin
        general_purpose_nv_bit[cmd_arg[1:0]] <= 1'b0;
      end
    end
  end

  // Lock bits, one per 64-page region
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_bits <= '0;
    end else if (clk_en) begin
      if (erase_pulse) begin
        lock_bits <= '0;
      end else if (cmd_take && !cmd_deny && cmd_code == CMD_SET_LOCK) begin
        lock_bits[cmd_arg[LOCK_SHIFT +: LIDX_W]] <= 1'b1;
      end else if (cmd_take && !cmd_deny && cmd_code == CMD_CLR_LOCK) begin
        lock_bits[cmd_arg[LOCK_SHIFT +: LIDX_W]] <= 1'b0;
      end
    end
  end

  // Security: set by command only, cleared by erase pin followed by full erase
  always_ff @(posedge clk) begin
    if (reset) begin
      security_on <= 1'b0;
      erase_armed <= 1'b0;
    end else if (clk_en) begin
      if (cst == C_BUSY && flash_op_done && busy_code == CMD_ERASE_ALL
          && erase_armed) begin
        security_on <= 1'b0;
        erase_armed <= 1'b0;
      end else if (cmd_take && !cmd_deny && cmd_code == CMD_SET_SEC) begin
        security_on <= 1'b1;
      end
      // Arming is separate so a same-cycle set command is never lost
      if (erase_pulse) begin
        erase_armed <= 1'b1;
      end
    end
  end

  // Remap is a one-way switch until reset
  always_ff @(posedge clk) begin
    if (reset) begin
      remap <= 1'b0;
    end else if (cmd_take && !cmd_deny && cmd_code == CMD_REMAP) begin
      remap <= 1'b1;
    end
  end

  // Write buffer fill and array-side read
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (acc_take && !acc_deny && acc_write && dec_region == RG_FLASH) begin
        wbuf[dec_offset[WBUF_IDX_W+1:2]] <= acc_wdata;
      end
      flash_wbuf_data <= wbuf[flash_wbuf_idx];
    end
  end

  // Access sequencer: decode answer, prefetch hits, fill then prefetch next
  always_ff @(posedge clk) begin
    if (reset) begin
      ast <= A_IDLE;
      acc_ack <= 1'b0;
      acc_refused <= 1'b0;
      acc_region <= RG_NONE;
      acc_offset <= '0;
      acc_rdata <= '0;
      flash_rd_req <= 1'b0;
      flash_rd_addr <= '0;
      pf_vld <= '0;
      pf_victim <= 1'b0;
      for (int i = 0; i < PF_ENTRIES; i++) begin
        pf_data[i] <= '0;
        pf_tag[i] <= '0;
      end
    end else if (clk_en) begin
      acc_ack <= 1'b0;
      acc_refused <= 1'b0;
      case (ast)
        A_IDLE: begin
          if (acc_valid) begin
            acc_region <= dec_region;
            acc_offset <= dec_offset;
            if (acc_deny) begin
              acc_ack <= 1'b1;
              acc_refused <= 1'b1;
            end else if (dec_region == RG_FLASH && !acc_write && |pf_hit) begin
              acc_rdata <= pf_hit[0] ? pf_data[0] : pf_data[1];
              acc_ack <= 1'b1;
            end else if (dec_region == RG_FLASH && !acc_write) begin
              flash_rd_req <= 1'b1;
              flash_rd_addr <= acc_word;
              ast <= A_FILL;
            end else begin
              acc_ack <= 1'b1;
            end
          end
        end
        A_FILL: begin
          if (flash_rd_valid) begin
            pf_data[pf_victim] <= flash_rd_data;
            pf_tag[pf_victim] <= flash_rd_addr;
            pf_vld[pf_victim] <= 1'b1;
            pf_victim <= !pf_victim;
            acc_rdata <= flash_rd_data;
            acc_ack <= 1'b1;
            // Anticipate the next sequential word
            flash_rd_addr <= flash_rd_addr + 1'b1;
            ast <= A_PREF;
          end
        end
        A_PREF: begin
          if (flash_rd_valid) begin
            pf_data[pf_victim] <= flash_rd_data;
            pf_tag[pf_victim] <= flash_rd_addr;
            pf_vld[pf_victim] <= 1'b1;
            pf_victim <= !pf_victim;
            flash_rd_req <= 1'b0;
            ast <= A_IDLE;
          end
        end
        default: begin
          flash_rd_req <= 1'b0;
          ast <= A_IDLE;
        end
      endcase
      // Array contents change: stale prefetch words must go
      if (flash_op_start) begin
        pf_vld <= '0;
      end
    end
  end

  // Standby whenever no access is requested and neither read nor array work is pending
  always_ff @(posedge clk) begin
    if (reset) begin
      flash_standby <= 1'b1;
    end else if (clk_en) begin
      flash_standby <= !acc_valid && ast == A_IDLE && cst == C_IDLE;
    end
  end

  a_sram_zero_remap: assert property (
    @(posedge clk) disable iff (reset)
    acc_take && acc_addr[31:20] == 12'h000 && remap && !acc_deny
    |=> acc_region == RG_SRAM && acc_ack)
    else $error("zero window not SRAM after remap");
  a_rom_fixed: assert property (
    @(posedge clk) disable iff (reset)
    acc_take && acc_addr[31:20] == 12'h003 |=> acc_region == RG_ROM)
    else $error("ROM base not decoded");
  a_zero_boot_sel: assert property (
    @(posedge clk) disable iff (reset)
    acc_take && acc_addr[31:20] == 12'h000 && !remap
    |=> acc_region == ($past(general_purpose_nv_bit[GP_BOOT_FLASH]) ? RG_FLASH : RG_ROM))
    else $error("zero window ignores boot select");
  a_erase_clears: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && erase_pulse |=> general_purpose_nv_bit == 3'h0 && lock_bits == '0)
    else $error("erase pin left bits set");
  a_lock_abort: assert property (
    @(posedge clk) disable iff (reset)
    cmd_take && !cmd_deny && cmd_code == CMD_PROG_PAGE && cmd_page_locked
    |=> lock_abort && !flash_op_start && cst == C_IDLE)
    else $error("locked program not aborted");
  a_sec_refuse: assert property (
    @(posedge clk) disable iff (reset)
    acc_take && security_on && acc_src == SRC_DEBUG && dec_region == RG_FLASH
    |=> acc_ack && acc_refused)
    else $error("secured flash reached by debug");
  a_sec_sticky: assert property (
    @(posedge clk) disable iff (reset)
    security_on && !(cst == C_BUSY && flash_op_done && erase_armed) |=> security_on)
    else $error("security dropped without erase");
  a_standby: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && ast != A_IDLE |=> !flash_standby)
    else $error("standby during flash read");
  a_calib_const: assert property (
    @(posedge clk) disable iff (reset)
    calib_bits == CALIB_VALUE)
    else $error("calibration bits changed");
  a_fast_mode: assert property (
    @(posedge clk) disable iff (reset)
    $rose(fast_prog_mode) |-> $past(pin_ff2) == 3'h7)
    else $error("fast mode without all pins high");
endmodule : fnv_nvm_ctrl

/* File: bench/fnv_flash_model.sv */
// Flash array stand-in: answers word reads and array operations.
// Assumes the controller holds its read request level until answered.
module fnv_flash_model
  import fnv_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic reset,
  // Read side
  input wire logic flash_rd_req,
  input wire logic [FLASH_WORD_W-1:0] flash_rd_addr,
  output logic flash_rd_valid,
  output logic [31:0] flash_rd_data,
  // Array operations and write buffer walk
  input wire logic flash_op_start,
  output logic flash_op_done,
  output logic [WBUF_IDX_W-1:0] flash_wbuf_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] rd_wait; // Cycles the read has waited
  logic [2:0] op_wait; // Cycles left in an array operation
  // Read answered two cycles late; data coded from the word address
  always_ff @(posedge clk) begin
    if (reset || !flash_rd_req || flash_rd_valid) rd_wait <= 2'h0;
    else rd_wait <= rd_wait + 2'h1;
    flash_rd_valid <= !reset && flash_rd_req && !flash_rd_valid && rd_wait == 2'h1;
    // Stale data flips every cycle so an old word never looks valid
    flash_rd_data <= (rd_wait == 2'h1) ? {16'hC0DE, flash_rd_addr} : ~flash_rd_data;
  end
  // Array operation finishes a few cycles after its start
  always_ff @(posedge clk) begin
    if (reset) op_wait <= 3'h0;
    else if (flash_op_start) op_wait <= 3'h4;
    else if (op_wait != 3'h0) op_wait <= op_wait - 3'h1;
    flash_op_done <= !reset && op_wait == 3'h1;
    flash_wbuf_idx <= reset ? 6'h00 : flash_wbuf_idx + 6'h01;
  end
endmodule : fnv_flash_model

/* File: bench/tb_flash_nvm_bits_and_boot_map.sv */
// Self-checking bench for the boot map and non-volatile bit controller.
// Assumes the flash model sits on the array side; debounce shortened to 16.
module tb_flash_nvm_bits_and_boot_map import fnv_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, clk_en = 1, erase_pin = 0, test_mode_pin = 0, rf;
  logic port_a_line_zero = 0, port_a_line_one = 0, cmd_valid = 0, acc_valid = 0, acc_write = 0;
  fnv_cmd_e cmd_code = CMD_REMAP, flash_op_code;
  fnv_src_e cmd_src = SRC_CPU, acc_src = SRC_CPU;
  logic [PAGE_W-1:0] cmd_arg = '0, flash_op_page, pg;
  logic [31:0] acc_addr = '0, acc_wdata = '0, acc_rdata, flash_rd_data, flash_wbuf_data;
  logic cmd_busy, cmd_done, cmd_refused, lock_abort, acc_ack, acc_refused, flash_rd_req;
  logic flash_rd_valid, flash_op_start, flash_op_done, flash_standby, remap, security_on;
  logic fast_prog_mode;
  fnv_region_e acc_region;
  logic [OFFSET_W-1:0] acc_offset;
  logic [FLASH_WORD_W-1:0] flash_rd_addr;
  logic [WBUF_IDX_W-1:0] flash_wbuf_idx;
  logic [GP_COUNT-1:0] general_purpose_nv_bit;
  logic [15:0] lock_bits;
  logic [7:0] calib_bits;
  logic [2:0] r; // Answer of last command: abort, refused, done
  int err_total = 0, check_count = 0, seed = 32'hf078b9b3, k;
  // Controller under test, large part
  fnv_nvm_ctrl #(.NUM_LOCKS(16), .ERASE_DEBOUNCE(16), .CALIB_VALUE(8'h5A)) i_fnv_nvm_ctrl (
    .clk, .reset, .clk_en, .erase_pin, .test_mode_pin, .port_a_line_zero, .port_a_line_one,
    .cmd_valid, .cmd_code, .cmd_src, .cmd_arg, .cmd_busy, .cmd_done, .cmd_refused, .lock_abort,
    .acc_valid, .acc_write, .acc_src, .acc_addr, .acc_wdata, .acc_ack, .acc_refused,
    .acc_region, .acc_offset, .acc_rdata, .flash_rd_req, .flash_rd_addr, .flash_rd_valid,
    .flash_rd_data, .flash_op_start, .flash_op_code, .flash_op_page, .flash_op_done,
    .flash_wbuf_idx, .flash_wbuf_data, .flash_standby, .remap, .general_purpose_nv_bit,
    .lock_bits, .security_on, .fast_prog_mode, .calib_bits);
  // Flash array partner
  fnv_flash_model i_fnv_flash_model (.clk, .reset, .flash_rd_req, .flash_rd_addr,
    .flash_rd_valid, .flash_rd_data, .flash_op_start, .flash_op_done, .flash_wbuf_idx);
  initial forever #20 clk = ~clk;
  // Expected flash word for a byte address
  function automatic logic [31:0] fw(input logic [31:0] a);
    return {16'hC0DE, a[17:2]};
  endfunction : fw
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // Hang guard: counts as a mismatch and closes the run
  task automatic tmo;
    chk(0, 1, "handshake wait");
    report_and_stop;
  endtask : tmo
  // One-cycle request; taken at once since busy is low between commands
  task automatic cmd(input fnv_cmd_e c, input fnv_src_e s, input logic [PAGE_W-1:0] a);
    int n = 0;
    @(negedge clk);
    cmd_valid = 1;
    cmd_code = c;
    cmd_src = s;
    cmd_arg = a;
    do begin
      @(negedge clk);
      cmd_valid = 0;
      n++;
    end while (!(cmd_done === 1'b1 || cmd_refused === 1'b1 || lock_abort === 1'b1) && n < 60);
    if (n == 60) tmo;
    r = {lock_abort, cmd_refused, cmd_done};
  endtask : cmd
  // Access held until the acknowledge is seen
  task automatic acc(input fnv_src_e s, input logic [31:0] a, input logic w);
    int n = 0;
    @(negedge clk);
    acc_valid = 1;
    acc_src = s;
    acc_addr = a;
    acc_write = w;
    acc_wdata = $random(seed);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (acc_ack !== 1'b1 && n < 60);
    if (n == 60) tmo;
    rf = acc_refused;
    @(negedge clk);
    acc_valid = 0;
  endtask : acc
  initial begin
    repeat (4) @(negedge clk);
    reset = 0;
    acc(SRC_CPU, 32'h0020_0010, 0);
    chk(acc_region, RG_SRAM, "sram");
    chk(acc_offset, 20'h00010, "offset");
    acc(SRC_CPU, 32'h0000_0010, 0);
    chk(acc_region, RG_ROM, "zero rom");
    acc(SRC_CPU, 32'h0030_0000, 1);
    chk(rf, 1, "rom write");
    acc(SRC_CPU, 32'h0040_0000, 0);
    chk(rf, 1, "unmapped");
    acc(SRC_CPU, 32'h0010_0010, 0);
    chk(acc_rdata, fw(32'h10), "flash");
    chk(flash_rd_addr, 16'h0005, "next word");
    acc(SRC_CPU, 32'h0010_0014, 0);
    chk(acc_rdata, fw(32'h14), "prefetch");
    chk(flash_rd_req, 0, "hit no fetch");
    @(negedge clk);
    chk(flash_standby, 1, "standby");
    $display("test map done");
    pg = $random(seed);
    cmd(CMD_SET_LOCK, SRC_CPU, pg);
    chk(lock_bits, 16'h1 << pg[9:6], "lock");
    cmd(CMD_PROG_PAGE, SRC_CPU, pg);
    chk(r, 3'b100, "locked prog");
    cmd(CMD_ERASE_PAGE, SRC_CPU, pg ^ 10'h040);
    chk(r, 3'b001, "other region");
    cmd(CMD_CLR_LOCK, SRC_CPU, pg);
    chk(lock_bits, 0, "unlock");
    cmd(CMD_PROG_PAGE, SRC_CPU, pg);
    chk(r, 3'b001, "prog");
    chk(flash_op_page, pg, "op page");
    chk(flash_op_code, CMD_PROG_PAGE, "op code");
    chk(cmd_busy, 0, "busy end");
    cmd(CMD_SET_LOCK, SRC_CPU, 10'h3FF);
    chk(lock_bits, 16'h8000, "top lock");
    $display("test locks done");
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_SET_GP, SRC_CPU, PAGE_W'(i));
      chk(general_purpose_nv_bit[i], 1, "gp set");
    end
    cmd(CMD_SET_GP, SRC_CPU, 10'h003);
    chk(r, 3'b010, "gp index");
    cmd(CMD_CLR_GP, SRC_CPU, 10'h001);
    chk(general_purpose_nv_bit, 3'h5, "gp clr");
    acc(SRC_CPU, 32'h0000_0000, 0);
    chk(acc_region, RG_FLASH, "zero flash");
    acc(SRC_CPU, 32'h0010_0008, 1);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (flash_wbuf_idx != 6'h03 && k < 70);
    if (k == 70) tmo;
    chk(flash_wbuf_data, acc_wdata, "wbuf");
    cmd(CMD_SET_GP, SRC_CPU, 10'h001);
    $display("test gp done");
    cmd(CMD_SET_SEC, SRC_CPU, 0);
    chk(security_on, 1, "secure");
    acc(SRC_DEBUG, 32'h0010_0000, 0);
    chk(rf, 1, "debug read");
    @(negedge clk);
    test_mode_pin = 1;
    port_a_line_zero = 1;
    port_a_line_one = 1;
    repeat (5) @(negedge clk);
    chk(fast_prog_mode, 1, "fast mode");
    cmd(CMD_ERASE_PAGE, SRC_FASTPROG, 0);
    chk(r, 3'b010, "fast secured");
    test_mode_pin = 0;
    erase_pin = 1;
    repeat (24) @(negedge clk);
    erase_pin = 0;
    repeat (4) @(negedge clk);
    chk(general_purpose_nv_bit, 0, "erase gp");
    chk(lock_bits, 0, "erase locks");
    chk(calib_bits, 8'h5A, "calib");
    chk(security_on, 1, "still secure");
    cmd(CMD_ERASE_ALL, SRC_CPU, 0);
    chk(security_on, 0, "unsecure");
    $display("test erase done");
    cmd(CMD_REMAP, SRC_CPU, 0);
    chk(remap, 1, "remap");
    acc(SRC_CPU, 32'h0000_0020, 0);
    chk(acc_region, RG_SRAM, "zero sram");
    acc(SRC_CPU, 32'h0010_0000, 0);
    chk(acc_region, RG_FLASH, "flash base");
    $display("test remap done");
    report_and_stop;
  end
endmodule : tb_flash_nvm_bits_and_boot_map
